// ---- rtl/mem_pin_cfg.svh ----
// constants for the memory pin clock and select control
`ifndef MEM_PIN_CFG_SVH
`define MEM_PIN_CFG_SVH
`define NUM_CLK_PINS    3
`define NUM_CS          6
`define CS_IDX_W        3
`define CNT_W           4
`define DIV_W           8
`define PIN_ROM         0
`define RST_FREE_RUN    3'h7
`define RST_FULL_RATE   3'h0
`define RST_PIN_ON      3'h0
`define RST_CKE_ON      1'h0
`define RST_CS_N        6'h3F
`define RST_RW          1'h0
`define DIV_CNT_ZERO    8'h00
`define DIV_CNT_ONE     8'h01
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define MC_HALF_CYC     8'h02
`define SETUP_CYC       4'h1
`define STROBE_CYC      4'h3
`endif

// ---- rtl/mem_pin_pkg.sv ----
// types shared by the memory pin clock and select control
package mem_pin_pkg;
    // software-written pin control word
    typedef struct packed {
        logic [2:0] free_run;
        logic [2:0] full_rate;
        logic [2:0] pin_on;
        logic       cke_on;
    } clk_ctrl_t;

    // one static access request
    typedef struct packed {
        logic       write;
        logic [2:0] cs_idx;
    } acc_req_t;

    // static access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_SETUP    = 3'b001,
        ST_STROBE   = 3'b010,
        ST_WAIT_RDY = 3'b011,
        ST_HOLD     = 3'b100
    } acc_state_t;
endpackage

// ---- rtl/clk_pin_gen.sv ----
// one memory clock pin: full or half rate, stops only when low
`timescale 1ns/1ps
`default_nettype none
module clk_pin_gen (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic run_i,
    input  wire logic full_rate_i,
    input  wire logic tick_full_i,
    input  wire logic tick_half_i,
    input  wire logic force_low_i,
    // pin
    output logic      pin_o
);
    logic pin_ff;
    logic nxt_pin;
    wire  toggle = full_rate_i ? tick_full_i : tick_half_i;

    // a clock stopped by run_i finishes its high phase so no runt pulse leaves; force_low_i drops it at once
    assign nxt_pin = force_low_i ? 1'b0 :
                     (toggle && (run_i || pin_ff)) ? ~pin_ff : pin_ff;

    // pin flop, low in reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    assign pin_o = pin_ff;
endmodule
`default_nettype wire

// ---- rtl/memory_pin_clock_and_select_control.sv ----
// memory pin clock, clock enable, chip select and strobe control
`timescale 1ns/1ps
`default_nettype none
`include "mem_pin_cfg.svh"
module memory_pin_clock_and_select_control
    import mem_pin_pkg::*;
#(
    parameter logic [7:0] MC_HALF_CYC = `MC_HALF_CYC,
    parameter logic [3:0] SETUP_CYC   = `SETUP_CYC,
    parameter logic [3:0] STROBE_CYC  = `STROBE_CYC
) (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_n_i,
    // power state
    input  wire logic                 sleep_i,
    // pin control word
    input  wire logic                 ctrl_wr_i,
    input  wire clk_ctrl_t            ctrl_i,
    output clk_ctrl_t                 ctrl_o,
    // boot strap: bank 0 holds a synchronous static rom
    input  wire logic                 boot_sync_rom_i,
    // per chip select variable latency enable
    input  wire logic [`NUM_CS-1:0]   cs_vlio_i,
    // static access request and completion
    input  wire logic                 acc_valid_i,
    input  wire acc_req_t             acc_req_i,
    output logic                      acc_ready_o,
    output logic                      acc_done_o,
    output logic                      acc_busy_o,
    // external pins
    input  wire logic                 ready_pin_i,
    input  wire logic                 alt_master_request_in_i,
    output logic                      alt_master_grant_out_o,
    output logic                      sdram_clk_enable_out_o,
    output logic                      sync_rom_clock_out_o,
    output logic [1:0]                sdram_clock_outs_o,
    output logic [`NUM_CS-1:0]        static_chip_selects_n_o,
    output logic                      static_rw_strobe_o
);
    // active-low chip select mask for one index, all high when out of range
    function automatic logic [`NUM_CS-1:0] cs_decode(input logic [2:0] idx);
        logic [`NUM_CS-1:0] m;
        m = `RST_CS_N;
        if (idx < `CS_IDX_W'(`NUM_CS)) begin
            m[idx] = 1'b0;
        end
        return m;
    endfunction

    // reset release synchroniser
    logic rst_meta_ff;
    logic rst_sync_ff;
    wire  rst_n = rst_sync_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // pin input synchronisers: ready, request, strap
    // cleared by the raw reset so the strap is through both flops when rst_n lifts
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
        end else begin
            pin_meta_ff <= {boot_sync_rom_i, alt_master_request_in_i, ready_pin_i};
            pin_sync_ff <= pin_meta_ff;
        end
    end
    wire rdy_s   = pin_sync_ff[0];
    wire req_s   = pin_sync_ff[1];
    wire strap_s = pin_sync_ff[2];

    // memory controller clock enables from the divider
    logic [`DIV_W-1:0] div_cnt_ff;
    logic              half_ph_ff;
    wire               tick_full = (div_cnt_ff == MC_HALF_CYC - `DIV_CNT_ONE);
    wire               tick_half = tick_full && half_ph_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= `DIV_CNT_ZERO;
            half_ph_ff <= 1'b0;
        end else begin
            div_cnt_ff <= tick_full ? `DIV_CNT_ZERO : div_cnt_ff + `DIV_CNT_ONE;
            half_ph_ff <= tick_full ? ~half_ph_ff : half_ph_ff;
        end
    end

    // control word: strap lands in the rom clock bit once after release
    clk_ctrl_t ctrl_ff;
    logic      init_done_ff;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff.free_run  <= `RST_FREE_RUN;
            ctrl_ff.full_rate <= `RST_FULL_RATE;
            ctrl_ff.pin_on    <= `RST_PIN_ON;
            ctrl_ff.cke_on    <= `RST_CKE_ON;
            init_done_ff      <= 1'b0;
        end else if (!init_done_ff) begin
            ctrl_ff.pin_on[`PIN_ROM] <= strap_s;
            init_done_ff             <= 1'b1;
        end else if (ctrl_wr_i) begin
            ctrl_ff <= ctrl_i;
        end
    end
    assign ctrl_o = ctrl_ff;

    // static access sequencer
    acc_state_t         state_ff;
    acc_state_t         nxt_state;
    logic [`CNT_W-1:0]  cnt_ff;
    logic [`CNT_W-1:0]  nxt_cnt;
    acc_req_t           acc_ff;
    logic               grant_ff;
    logic               nxt_grant;
    logic [`NUM_CS-1:0] cs_n_ff;
    logic [`NUM_CS-1:0] nxt_cs_n;
    logic               rw_ff;
    logic               nxt_rw;
    logic               done_ff;
    logic               cke_ff;

    wire idle       = (state_ff == ST_IDLE);
    wire take       = acc_valid_i && acc_ready_o;
    wire cnt_last   = (cnt_ff == `CNT_ONE);
    wire acc_vlio   = (acc_ff.cs_idx < `CS_IDX_W'(`NUM_CS)) && cs_vlio_i[acc_ff.cs_idx];
    wire acc_active = !idle;

    // new accesses only while idle, awake and not granted away
    assign acc_ready_o = idle && !sleep_i && !grant_ff;
    assign acc_busy_o  = acc_active;
    assign acc_done_o  = done_ff;

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = ST_SETUP;
                    nxt_cnt   = SETUP_CYC;
                end
            end
            ST_SETUP: begin
                nxt_cnt = cnt_ff - `CNT_ONE;
                if (cnt_last) begin
                    nxt_state = ST_STROBE;
                    nxt_cnt   = STROBE_CYC;
                end
            end
            ST_STROBE: begin
                nxt_cnt = cnt_ff - `CNT_ONE;
                if (cnt_last) begin
                    nxt_state = acc_vlio ? ST_WAIT_RDY : ST_HOLD;
                end
            end
            ST_WAIT_RDY: begin
                if (rdy_s) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // chip selects and strobe: set on take; chip selects released on hold, strobe keeps its level
    assign nxt_cs_n = take ? cs_decode(acc_req_i.cs_idx) :
                      (state_ff == ST_HOLD) ? `RST_CS_N : cs_n_ff;
    assign nxt_rw   = take ? !acc_req_i.write : rw_ff;

    // grant held while the request stays up
    assign nxt_grant = grant_ff ? req_s : (req_s && idle && !sleep_i);

    // sequencer registers
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= `CNT_ZERO;
            acc_ff   <= '0;
            cs_n_ff  <= `RST_CS_N;
            rw_ff    <= `RST_RW;
            done_ff  <= 1'b0;
            grant_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            acc_ff   <= take ? acc_req_i : acc_ff;
            cs_n_ff  <= nxt_cs_n;
            rw_ff    <= nxt_rw;
            done_ff  <= (state_ff == ST_HOLD);
            grant_ff <= nxt_grant;
        end
    end

    // sdram clock enable flop
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cke_ff <= 1'b0;
        end else begin
            cke_ff <= ctrl_ff.cke_on && !sleep_i;
        end
    end

    // clock pins: bit 0 rom, bit 1 banks 0/1, bit 2 banks 2/3
    logic [`NUM_CLK_PINS-1:0] clk_pins;
    wire  [`NUM_CLK_PINS-1:0] pin_run =
        ctrl_ff.pin_on & (ctrl_ff.free_run | {`NUM_CLK_PINS{acc_active}});
    genvar g;
    generate
        for (g = 0; g < `NUM_CLK_PINS; g = g + 1) begin : g_clk
            clk_pin_gen u_pin (
                .clk_i       (ref_clk_i),
                .rst_n_i     (rst_n),
                .run_i       (pin_run[g]),
                .full_rate_i (ctrl_ff.full_rate[g]),
                .tick_full_i (tick_full),
                .tick_half_i (tick_half),
                .force_low_i (sleep_i),
                .pin_o       (clk_pins[g])
            );
        end
    endgenerate

    // output pins
    assign sync_rom_clock_out_o    = clk_pins[`PIN_ROM];
    assign sdram_clock_outs_o      = clk_pins[2:1];
    assign sdram_clk_enable_out_o  = cke_ff;
    assign static_chip_selects_n_o = cs_n_ff;
    assign static_rw_strobe_o      = rw_ff;
    assign alt_master_grant_out_o  = grant_ff;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    sequence sleep_two_s;
        sleep_i [*2];
    endsequence

    sequence vlio_stall_s;
        (state_ff == ST_WAIT_RDY) && !rdy_s;
    endsequence

    cke_sleep_low_a: assert property (sleep_i |=> !sdram_clk_enable_out_o)
        else $error("clock enable high during sleep");
    cke_reset_low_a: assert property ($rose(rst_n) |-> !sdram_clk_enable_out_o
        && static_chip_selects_n_o[0] && !static_rw_strobe_o)
        else $error("pin not at reset state after release");
    cke_cmd_off_a: assert property (init_done_ff && ctrl_wr_i && !ctrl_i.cke_on
        |=> ##1 !sdram_clk_enable_out_o)
        else $error("clock enable not dropped on command");
    clk_half_rate_a: assert property (!ctrl_ff.full_rate[2] && pin_run[2] && tick_half
        && !sleep_i && !ctrl_wr_i |=> $changed(sdram_clock_outs_o[1]))
        else $error("sdram clock did not toggle on half tick");
    clk_sleep_low_a: assert property (sleep_two_s |-> sdram_clock_outs_o == 2'b00
        && !sync_rom_clock_out_o)
        else $error("clock pin high during sleep");
    rom_strap_a: assert property ($rose(init_done_ff)
        |-> ctrl_ff.pin_on[`PIN_ROM] == $past(strap_s))
        else $error("rom clock bit not loaded from strap");
    rw_sleep_hold_a: assert property (sleep_i && idle |=> $stable(static_rw_strobe_o))
        else $error("strobe changed during sleep");
    vlio_wait_a: assert property (vlio_stall_s |=> !acc_done_o && state_ff != ST_IDLE)
        else $error("variable latency access ended without ready");
    grant_req_a: assert property (alt_master_grant_out_o |-> $past(req_s))
        else $error("grant without request");
    cs_single_a: assert property ($countones(~static_chip_selects_n_o) <= 1)
        else $error("more than one chip select low");
    cs_release_a: assert property (acc_done_o |-> static_chip_selects_n_o == `RST_CS_N)
        else $error("chip select still low at completion");
endmodule
`default_nettype wire

// ---- testbench/mem_dev_model.sv ----
// behavioural variable latency static memory device
`timescale 1ns/1ps
`default_nettype none
module mem_dev_model (
    // clock
    input  wire logic       clk_i,
    // static bus
    input  wire logic [5:0] cs_n_i,
    input  wire logic [7:0] wait_cyc_i,
    output logic            ready_o
);
    logic [7:0] sel_cnt_ff;

    // count cycles since the device was selected
    always_ff @(posedge clk_i) begin
        if (cs_n_i == 6'h3F) begin
            sel_cnt_ff <= 8'h00;
        end else if (sel_cnt_ff != 8'hFF) begin
            sel_cnt_ff <= sel_cnt_ff + 8'h01;
        end
    end

    // pulled up while idle, low once selected until the wait runs out
    assign ready_o = (cs_n_i == 6'h3F) | (sel_cnt_ff >= wait_cyc_i);
endmodule
`default_nettype wire

// ---- testbench/memory_pin_clock_and_select_control_test.sv ----
// self-checking bench for the memory pin clock and select control
`timescale 1ns/1ps
`default_nettype none
module memory_pin_clock_and_select_control_test
    import mem_pin_pkg::*;
;
    localparam logic [7:0] MC_C     = 8'h02;
    localparam logic [3:0] SETUP_C  = 4'h1;
    localparam logic [3:0] STROBE_C = 4'h3;
    localparam int         LAT      = 2 + SETUP_C + STROBE_C;
    localparam int         TOG_F    = 32 / MC_C;
    localparam int         TOG_H    = 32 / (2 * MC_C);

    logic       ref_clk, reset_n, sleep, ctrl_wr, boot_rom, acc_valid, acc_ready;
    logic       acc_done, acc_busy, ready_pin, alt_req, alt_gnt, cke, rom_clk, rw;
    logic [1:0] sd_clk;
    logic [5:0] vlio, cs_n;
    logic [7:0] dev_wait;
    clk_ctrl_t  ctrl_in, ctrl_out;
    acc_req_t   acc_req;
    int         n_fail, checks_done, t0, t1, t2;

    // free running reference clock
    always #4 ref_clk = ~ref_clk;

    memory_pin_clock_and_select_control #(
        .MC_HALF_CYC(MC_C),
        .SETUP_CYC  (SETUP_C),
        .STROBE_CYC (STROBE_C)
    ) u_memory_pin_clock_and_select_control (
        .ref_clk_i              (ref_clk),
        .reset_n_i              (reset_n),
        .sleep_i                (sleep),
        .ctrl_wr_i              (ctrl_wr),
        .ctrl_i                 (ctrl_in),
        .ctrl_o                 (ctrl_out),
        .boot_sync_rom_i        (boot_rom),
        .cs_vlio_i              (vlio),
        .acc_valid_i            (acc_valid),
        .acc_req_i              (acc_req),
        .acc_ready_o            (acc_ready),
        .acc_done_o             (acc_done),
        .acc_busy_o             (acc_busy),
        .ready_pin_i            (ready_pin),
        .alt_master_request_in_i(alt_req),
        .alt_master_grant_out_o (alt_gnt),
        .sdram_clk_enable_out_o (cke),
        .sync_rom_clock_out_o   (rom_clk),
        .sdram_clock_outs_o     (sd_clk),
        .static_chip_selects_n_o(cs_n),
        .static_rw_strobe_o     (rw)
    );

    mem_dev_model u_mem_dev_model (
        .clk_i     (ref_clk),
        .cs_n_i    (cs_n),
        .wait_cyc_i(dev_wait),
        .ready_o   (ready_pin)
    );

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // a wait ran out of its bound
    task automatic give_up;
        chk("wait bound", 1, 0);
        stop_test();
    endtask

    // n edges, then settle 1 ns past the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_ctrl(input clk_ctrl_t v);
        ctrl_in = v;
        ctrl_wr = 1'b1;
        cyc(1);
        ctrl_wr = 1'b0;
        chk("ctrl_o", v, ctrl_out);
    endtask

    // toggles seen on rom, sdram0 and sdram1 clock pins over n cycles
    task automatic count_tog(input int n, output int c0, output int c1, output int c2);
        logic [2:0] prev;
        prev = {sd_clk, rom_clk};
        c0 = 0;
        c1 = 0;
        c2 = 0;
        repeat (n) begin
            cyc(1);
            c0 += int'(rom_clk !== prev[0]);
            c1 += int'(sd_clk[0] !== prev[1]);
            c2 += int'(sd_clk[1] !== prev[2]);
            prev = {sd_clk, rom_clk};
        end
    endtask

    // one static access, latency counted from the take edge
    task automatic access(input logic [2:0] idx, input logic wr, input int lo, input int hi);
        int         n;
        logic [5:0] exp_cs;
        exp_cs = (idx < 3'h6) ? ~(6'h01 << idx) : 6'h3F;
        n = 0;
        while (acc_ready !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 50) give_up();
        end
        acc_valid = 1'b1;
        acc_req = '{write: wr, cs_idx: idx};
        cyc(1);
        acc_valid = 1'b0;
        n = 1;
        chk("chip selects", exp_cs, cs_n);
        chk("rw strobe", !wr, rw);
        chk("busy", 1, acc_busy);
        while (acc_done !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 100) give_up();
        end
        chk("latency in range", 1, n >= lo && n <= hi);
        cyc(1);
        chk("done pulse", 0, acc_done);
        chk("idle again", 0, acc_busy);
    endtask

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        sleep = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_in = '0;
        boot_rom = 1'b1;
        vlio = 6'h00;
        acc_valid = 1'b0;
        acc_req = '0;
        alt_req = 1'b0;
        dev_wait = 8'h0C;
        n_fail = 0;
        checks_done = 0;
        // look at the reset state once an edge has passed, not at time zero
        cyc(2);
        chk("cke in reset", 0, cke);
        chk("cs in reset", 6'h3F, cs_n);
        chk("pins in reset", 4'h0, {rw, sd_clk, rom_clk});
        cyc(14);
        reset_n = 1'b1;
        cyc(4);
        chk("ctrl reset", {3'h7, 3'h0, 3'h1, 1'h0}, ctrl_out);
        count_tog(32, t0, t1, t2);
        chk("rom half rate", TOG_H, t0);
        chk("sdram idle", 0, t1 + t2);
        wr_ctrl('{3'h7, 3'h2, 3'h7, 1'b1});
        cyc(2);
        chk("cke on", 1, cke);
        count_tog(32, t0, t1, t2);
        chk("rom rate", TOG_H, t0);
        chk("sdram0 full", TOG_F, t1);
        chk("sdram1 half", TOG_H, t2);
        for (int i = 0; i < 7; i++) begin
            access(i[2:0], i[0], LAT, LAT);
        end
        vlio = 6'h08;
        access(3'h3, 1'b1, 12, 22);
        dev_wait = 8'h00;
        access(3'h3, 1'b0, LAT, LAT + 4);
        sleep = 1'b1;
        cyc(2);
        chk("cke sleep", 0, cke);
        count_tog(16, t0, t1, t2);
        chk("clocks in sleep", 0, t0 + t1 + t2 + {sd_clk, rom_clk});
        chk("rw holds", 1, rw);
        chk("no access asleep", 0, acc_ready);
        sleep = 1'b0;
        alt_req = 1'b1;
        t0 = 0;
        while (alt_gnt !== 1'b1) begin
            cyc(1);
            t0++;
            if (t0 > 8) give_up();
        end
        chk("granted blocks", 0, acc_ready);
        alt_req = 1'b0;
        cyc(6);
        chk("grant drops", 0, alt_gnt);
        wr_ctrl('{3'h0, 3'h0, 3'h7, 1'b0});
        cyc(12);
        count_tog(16, t0, t1, t2);
        chk("clocks stopped", 0, t0 + t1 + t2 + {sd_clk, rom_clk});
        chk("cke off", 0, cke);
        wr_ctrl('{3'h7, 3'h0, 3'h7, 1'b1});
        cyc(2);
        boot_rom = 1'b0;
        reset_n = 1'b0;
        #1;
        chk("cke reset", 0, cke);
        chk("clocks reset", 0, {sd_clk, rom_clk});
        cyc(16);
        reset_n = 1'b1;
        cyc(4);
        chk("ctrl no rom", {3'h7, 3'h0, 3'h0, 1'h0}, ctrl_out);
        count_tog(16, t0, t1, t2);
        chk("rom off", 0, t0);
        stop_test();
    end
endmodule
`default_nettype wire
